// file: rtl/arc_pkg.sv
// Shared constants for the autorange converter controller
package arc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // APB register map, byte addresses
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] RES_OFS = 8'h08;
   localparam logic [7:0] CONV_OFS = 8'h0c;

   // Control register fields
   localparam int CTRL_FUNC_LSB = 0;
   localparam int CTRL_HOLD_BIT = 2;
   localparam int CTRL_AC_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;

   // Status register fields
   localparam int STAT_SEL_LSB = 0;
   localparam int STAT_OVER_BIT = 3;
   localparam int STAT_UNDER_BIT = 4;
   localparam int STAT_BLANK_BIT = 5;
   localparam int STAT_SIGN_BIT = 6;
   localparam int STAT_HALF_BIT = 7;

   ////////////////////////////////////////////////////////////////////////
   // Converter pin side
   localparam int DIGITS = 4;
   localparam int NRANGE = 4;
   localparam int SEL_W = NRANGE - 1;
   localparam int HALF_DIGIT_BIT = 3;
   localparam int SIGN_BIT = 2;
   localparam int OUT_OF_LIMITS_BIT = 0;
   localparam logic [SEL_W-1:0] SEL_TOP = 3'h7;
   localparam logic [SEL_W-1:0] SEL_RST = 3'h0;

   // Function encodings held in the control register
   localparam logic [1:0] FN_VOLT = 2'h0;
   localparam logic [1:0] FN_CURR = 2'h1;
   localparam logic [1:0] FN_OHM = 2'h2;

   // Unit indicator codes
   localparam logic [2:0] UNIT_MV = 3'h0;
   localparam logic [2:0] UNIT_V = 3'h1;
   localparam logic [2:0] UNIT_MA = 3'h2;
   localparam logic [2:0] UNIT_A = 3'h3;
   localparam logic [2:0] UNIT_KOHM = 3'h4;

   // Decimal point: digits right of the point
   localparam logic [1:0] DP_NONE = 2'h0;
   localparam logic [1:0] DP_ONE = 2'h1;
   localparam logic [1:0] DP_TWO = 2'h2;
   localparam logic [1:0] DP_THREE = 2'h3;

endpackage : arc_pkg

// file: rtl/arc_pin_sync.sv
// Two-flop synchroniser for a group of converter pins
`timescale 1ns/1ps
`default_nettype none
module arc_pin_sync #(
   parameter int W = 9
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync
);

   logic [W-1:0] meta_q;

   ////////////////////////////////////////////////////////////////////////
   // Two flops per bit; first flop feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= pin_in[gi];
               pin_sync[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

endmodule : arc_pin_sync
`default_nettype wire

// file: rtl/arc_range_sel.sv
// Bidirectional range selector with exclusive-OR one-hot decode
`timescale 1ns/1ps
`default_nettype none
module arc_range_sel (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic shift_up,
   input wire logic shift_dn,
   output logic [arc_pkg::SEL_W-1:0] sel_q,
   output logic [arc_pkg::NRANGE-1:0] range_hot
);

   ////////////////////////////////////////////////////////////////////////
   // shift toward higher or lower
   // ones or zeros saturate by shifting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= arc_pkg::SEL_RST;
      end else if (shift_up) begin
         sel_q <= {sel_q[arc_pkg::SEL_W-2:0], 1'b1};
      end else if (shift_dn) begin
         sel_q <= {1'b0, sel_q[arc_pkg::SEL_W-1:1]};
      end
   end

   assign range_hot[0] = ~sel_q[0];
   assign range_hot[arc_pkg::NRANGE-1] = sel_q[arc_pkg::SEL_W-1];
   genvar gi;
   generate
      for (gi = 1; gi < arc_pkg::SEL_W; gi++) begin : g_xor
         assign range_hot[gi] = sel_q[gi-1] ^ sel_q[gi];
      end
   endgenerate

   one_hot_a: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot(range_hot))
      else $error("range decode not one-hot");

   top_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sel_q == arc_pkg::SEL_TOP) && shift_up |=> sel_q == arc_pkg::SEL_TOP)
      else $error("top range not held");

endmodule : arc_range_sel
`default_nettype wire

// file: rtl/arc_ctrl.sv
// Autorange controller for a multiplexed BCD dual-ramp converter
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module arc_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [arc_pkg::ADDR_W-1:0] paddr,
   input wire logic [arc_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [arc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] bcd_in,
   input wire logic [arc_pkg::DIGITS-1:0] digit_sel,
   input wire logic conv_done,
   output logic display_update,
   output logic [arc_pkg::NRANGE-1:0] relay,
   output logic ref_2v_on,
   output logic ref_200mv_on,
   output logic integ_low_r_on,
   output logic [arc_pkg::NRANGE-1:0] curr_route,
   output logic ac_path_on,
   output logic display_blank,
   output logic top_seg_bc,
   output logic [1:0] decimal_point_position,
   output logic [2:0] unit_code
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   logic [8:0] pins_s;
   logic [3:0] bcd_s;
   logic [arc_pkg::DIGITS-1:0] dsel_s;
   logic done_s;
   logic done_prev_q;
   logic conv_evt;

   arc_pin_sync #(
      .W(9)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in({conv_done, digit_sel, bcd_in}),
      .pin_sync(pins_s)
   );

   assign bcd_s = pins_s[3:0];
   assign dsel_s = pins_s[7:4];
   assign done_s = pins_s[8];

   // Edge of the done pulse; a slow converter clock keeps it wide enough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_prev_q <= 1'b0;
      end else begin
         done_prev_q <= done_s;
      end
   end
   assign conv_evt = done_s & ~done_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // Digit capture; index 0 is the top digit
   logic [3:0] dig_q [arc_pkg::DIGITS];
   logic [3:0] top_digit_code;

   genvar gi;
   generate
      for (gi = 0; gi < arc_pkg::DIGITS; gi++) begin : g_dig
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dig_q[gi] <= 4'h0;
            end else if (dsel_s[gi]) begin
               dig_q[gi] <= bcd_s;
            end
         end
      end
   endgenerate
   assign top_digit_code = dig_q[0];

   ////////////////////////////////////////////////////////////////////////
   // Top-digit decode
   logic half_digit_bit;
   logic sign_bit;
   logic out_of_limits_bit;
   logic over_now;
   logic under_limit_flag;

   assign half_digit_bit = top_digit_code[arc_pkg::HALF_DIGIT_BIT];
   assign sign_bit = top_digit_code[arc_pkg::SIGN_BIT];
   // kind of out-of-range from bit 3
   assign out_of_limits_bit = top_digit_code[arc_pkg::OUT_OF_LIMITS_BIT];
   assign over_now = out_of_limits_bit & ~half_digit_bit;
   assign under_limit_flag = out_of_limits_bit & half_digit_bit;

   ////////////////////////////////////////////////////////////////////////
   // Control register and APB slave
   logic [3:0] ctrl_q;
   logic [1:0] func;
   logic hold;
   logic wr_en;
   logic setup;
   logic [15:0] conv_cnt_q;
   logic [7:0] status_word;

   assign func = ctrl_q[arc_pkg::CTRL_FUNC_LSB +: 2];
   assign hold = ctrl_q[arc_pkg::CTRL_HOLD_BIT];
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite;
   // Zero wait states; read data is set up a cycle early
   assign pready = 1'b1;

   // Only byte lane 0 carries control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= arc_pkg::CTRL_RST;
      end else if (wr_en && paddr == arc_pkg::CTRL_OFS && pstrb[0]) begin
         ctrl_q <= pwdata[3:0];
      end
   end

   // Read mux registered in setup so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= 1'b0;
         prdata <= '0;
         unique case (paddr)
            arc_pkg::CTRL_OFS: prdata[3:0] <= ctrl_q;
            arc_pkg::STAT_OFS: prdata[7:0] <= status_word;
            arc_pkg::RES_OFS: prdata[15:0] <= {dig_q[0], dig_q[1],
                                               dig_q[2], dig_q[3]};
            arc_pkg::CONV_OFS: prdata[15:0] <= conv_cnt_q;
            default: pslverr <= 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Range stepping
   logic over_q;
   logic under_q;
   logic shift_up;
   logic shift_dn;
   logic [arc_pkg::SEL_W-1:0] sel_q;
   logic [arc_pkg::NRANGE-1:0] range_hot;

   // flags sampled at each done pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         over_q <= 1'b0;
         under_q <= 1'b0;
         conv_cnt_q <= 16'h0000;
      end else if (conv_evt) begin
         over_q <= over_now;
         under_q <= under_limit_flag;
         conv_cnt_q <= conv_cnt_q + 16'h0001;
      end
   end

   assign shift_up = conv_evt & over_now & ~hold;
   assign shift_dn = conv_evt & under_limit_flag & ~hold;

   arc_range_sel u_range (
      .pclk(pclk),
      .presetn(presetn),
      .shift_up(shift_up),
      .shift_dn(shift_dn),
      .sel_q(sel_q),
      .range_hot(range_hot)
   );

   ////////////////////////////////////////////////////////////////////////
   // Display blink on top-range overrange
   logic blank_q;

   // toggle each conversion, half the rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_q <= 1'b0;
      end else if (conv_evt) begin
         if (over_now && sel_q == arc_pkg::SEL_TOP) begin
            blank_q <= ~blank_q;
         end else begin
            blank_q <= 1'b0;
         end
      end
   end

   // Status bits gathered for the read mux
   always_comb begin
      status_word = 8'h00;
      status_word[arc_pkg::STAT_SEL_LSB +: arc_pkg::SEL_W] = sel_q;
      status_word[arc_pkg::STAT_OVER_BIT] = over_q;
      status_word[arc_pkg::STAT_UNDER_BIT] = under_q;
      status_word[arc_pkg::STAT_BLANK_BIT] = blank_q;
      status_word[arc_pkg::STAT_SIGN_BIT] = sign_bit;
      status_word[arc_pkg::STAT_HALF_BIT] = half_digit_bit;
   end

   ////////////////////////////////////////////////////////////////////////
   // Scale, point and unit for the present function and range
   logic use_200mv;
   logic [1:0] dp_d;
   logic [2:0] unit_d;

   assign use_200mv = (func == arc_pkg::FN_CURR) ||
                      (func != arc_pkg::FN_OHM && range_hot[0]);

   always_comb begin
      dp_d = arc_pkg::DP_ONE;
      unit_d = arc_pkg::UNIT_V;
      unique case (func)
         arc_pkg::FN_CURR: begin
            unit_d = range_hot[3] ? arc_pkg::UNIT_A : arc_pkg::UNIT_MA;
            if (range_hot[0] || range_hot[3]) begin
               dp_d = arc_pkg::DP_THREE;
            end else if (range_hot[1]) begin
               dp_d = arc_pkg::DP_TWO;
            end
         end
         arc_pkg::FN_OHM: begin
            unit_d = arc_pkg::UNIT_KOHM;
            if (range_hot[0]) begin
               dp_d = arc_pkg::DP_THREE;
            end else if (range_hot[1]) begin
               dp_d = arc_pkg::DP_TWO;
            end else if (range_hot[3]) begin
               dp_d = arc_pkg::DP_NONE;
            end
         end
         default: begin
            // Unused code 3 falls back to voltage
            if (range_hot[0]) begin
               unit_d = arc_pkg::UNIT_MV;
            end else if (range_hot[1]) begin
               dp_d = arc_pkg::DP_THREE;
            end else if (range_hot[2]) begin
               dp_d = arc_pkg::DP_TWO;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered pin outputs
   // done echoed to update pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         display_update <= 1'b0;
      end else begin
         display_update <= done_s;
      end
   end

   // low integrator resistance on 200 mV
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay <= 4'h0;
         ref_2v_on <= 1'b0;
         ref_200mv_on <= 1'b0;
         integ_low_r_on <= 1'b0;
         curr_route <= 4'h0;
         ac_path_on <= 1'b0;
      end else begin
         relay <= range_hot;
         ref_2v_on <= ~use_200mv;
         ref_200mv_on <= use_200mv;
         integ_low_r_on <= use_200mv;
         curr_route <= (func == arc_pkg::FN_CURR) ? range_hot : 4'h0;
         ac_path_on <= ctrl_q[arc_pkg::CTRL_AC_BIT];
      end
   end

   // leading one drives b and c
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         display_blank <= 1'b0;
         top_seg_bc <= 1'b0;
         decimal_point_position <= arc_pkg::DP_NONE;
         unit_code <= arc_pkg::UNIT_MV;
      end else begin
         display_blank <= blank_q;
         top_seg_bc <= ~half_digit_bit & ~blank_q;
         decimal_point_position <= dp_d;
         unit_code <= unit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // overrange moves range up
   shift_up_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_evt && over_now && !hold && sel_q != arc_pkg::SEL_TOP
      |=> sel_q == {$past(sel_q[1:0]), 1'b1})
      else $error("overrange did not step up");

   shift_dn_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_evt && under_limit_flag && !hold
      |=> sel_q == {1'b0, $past(sel_q[2:1])})
      else $error("underrange did not step down");

   keep_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      !shift_up && !shift_dn |=> $stable(sel_q))
      else $error("range moved without cause");

   hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      hold && conv_evt |=> $stable(sel_q))
      else $error("range moved under hold");

   echo_upd_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(done_s) |=> display_update)
      else $error("display update not echoed");

   ref_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 $past(func) == arc_pkg::FN_CURR |-> ref_200mv_on && !ref_2v_on)
      else $error("current mode without 200 mV reference");

   integ_path_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 integ_low_r_on == ref_200mv_on &&
      integ_low_r_on == (relay[0] ? $past(func) != arc_pkg::FN_OHM
                                  : $past(func) == arc_pkg::FN_CURR))
      else $error("integrator switch disagrees with reference");

   curr_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(func) != arc_pkg::FN_CURR |-> curr_route == 4'h0)
      else $error("sense route outside current mode");

   blink_tgl_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_evt && over_now && sel_q == arc_pkg::SEL_TOP
      |=> blank_q != $past(blank_q) ##1 display_blank == blank_q)
      else $error("blink did not toggle");

   seg_bc_a: assert property (@(posedge pclk) disable iff (!presetn)
      display_blank |-> !top_seg_bc)
      else $error("segments lit while blanked");

endmodule : arc_ctrl
`default_nettype wire

// file: verification/arc_conv_model.sv
// Behavioural model of the multiplexed BCD dual-ramp converter
`timescale 1ns/1ps
`default_nettype none
module arc_conv_model #(
   // conversion time, shortened to pclk cycles
   parameter int GAP = 6
) (
   input wire logic pclk,
   input wire logic display_update,
   output logic [3:0] bcd_in,
   output logic [3:0] digit_sel,
   output logic conv_done
);
   logic [15:0] latch_q = 16'he000;
   logic seen_q = 1'b0;
   logic prev_q = 1'b0;

   // Idle pins at time zero, no select active
   initial begin
      bcd_in = 4'ha;
      digit_sel = 4'h0;
      conv_done = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // update edge arms latch
   always @(posedge pclk) begin
      prev_q <= display_update;
      if (display_update && !prev_q) begin
         seen_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // code, scan, done pulse
   task automatic convert(input logic [15:0] code);
      // Without an update edge the old result is shown again
      if (seen_q) begin
         latch_q = code;
         seen_q = 1'b0;
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge pclk);
         digit_sel <= 4'h1 << k;
         bcd_in <= latch_q[15-4*k -: 4];
         repeat (4) @(posedge pclk);
         digit_sel <= 4'h0;
         // Blanked lines carry junk, never the last digit
         bcd_in <= ~latch_q[15-4*k -: 4];
      end
      repeat (GAP) @(posedge pclk);
      // Half a converter clock of 8 pclk
      conv_done <= 1'b1;
      repeat (4) @(posedge pclk);
      conv_done <= 1'b0;
   endtask : convert

endmodule : arc_conv_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the autorange converter controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, conv_done, display_update;
   logic [3:0] bcd_in, digit_sel, relay, curr_route;
   logic ref_2v_on, ref_200mv_on, integ_low_r_on, ac_path_on;
   logic display_blank, top_seg_bc;
   logic [1:0] decimal_point_position;
   logic [2:0] unit_code;
   int err_total = 0;
   int n_compared = 0;
   int upd_n = 0;
   // Point position per function and range, index func*4+range
   localparam logic [11:0][1:0] DP_TAB = {2'h0, 2'h1, 2'h2, 2'h3,
      2'h3, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h1};

   // 200 MHz clock
   always #2.5 pclk = ~pclk;

   // Count update pulses so the echo is checked per conversion
   always @(posedge display_update) upd_n++;

   arc_ctrl dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bcd_in(bcd_in), .digit_sel(digit_sel), .conv_done(conv_done),
      .display_update(display_update), .relay(relay),
      .ref_2v_on(ref_2v_on), .ref_200mv_on(ref_200mv_on),
      .integ_low_r_on(integ_low_r_on), .curr_route(curr_route),
      .ac_path_on(ac_path_on), .display_blank(display_blank),
      .top_seg_bc(top_seg_bc),
      .decimal_point_position(decimal_point_position),
      .unit_code(unit_code)
   );

   arc_conv_model u_conv (
      .pclk(pclk), .display_update(display_update), .bcd_in(bcd_in),
      .digit_sel(digit_sel), .conv_done(conv_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] d, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_total++;
         $display("Error apb_ready expected 1 seen %b", pready);
         end_of_test();
      end else begin
         d = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   // One conversion, then let the registered outputs settle
   task automatic conv(input logic [15:0] code);
      u_conv.convert(code);
      repeat (4) @(posedge pclk);
   endtask : conv

   task automatic chk_fn(input logic [1:0] f, input int r);
      logic [3:0] oh;
      logic lo;
      logic [2:0] un;
      oh = 4'h1 << r;
      lo = f == arc_pkg::FN_CURR || (f == arc_pkg::FN_VOLT && r == 0);
      if (f == arc_pkg::FN_OHM)
         un = arc_pkg::UNIT_KOHM;
      else if (f == arc_pkg::FN_CURR)
         un = r == 3 ? arc_pkg::UNIT_A : arc_pkg::UNIT_MA;
      else
         un = r == 0 ? arc_pkg::UNIT_MV : arc_pkg::UNIT_V;
      chk("relay", 32'(relay), 32'(oh));
      chk("ref_200mv", 32'(ref_200mv_on), 32'(lo));
      chk("ref_2v", 32'(ref_2v_on), 32'(!lo));
      chk("integ", 32'(integ_low_r_on), 32'(lo));
      chk("route", 32'(curr_route),
          f == arc_pkg::FN_CURR ? 32'(oh) : 32'h0);
      chk("dp", 32'(decimal_point_position),
          32'(DP_TAB[f*4+r]));
      chk("unit", 32'(unit_code), 32'(un));
   endtask : chk_fn

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      chk_fn(arc_pkg::FN_VOLT, 0);
      apb(1'b0, arc_pkg::CTRL_OFS, 32'h0, rd, er);
      chk("ctrl_rst", rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0, rd, er);
      chk("unmapped_err", 32'(er), 32'h1);
      chk("unmapped_rd", rd, 32'h0);
      apb(1'b1, arc_pkg::CTRL_OFS, 32'h8, rd, er);
      repeat (3) @(posedge pclk);
      chk("ac_path", 32'(ac_path_on), 32'h1);
      apb(1'b1, arc_pkg::CTRL_OFS, 32'h0, rd, er);
   endtask : t_reset

   // Every range under every function, climbing into saturation
   task automatic t_sweep;
      int n;
      conv(16'hf000);
      chk("bottom", 32'(relay), 32'h1);
      // No update edge yet, so the power-up code is still shown
      apb(1'b0, arc_pkg::RES_OFS, 32'h0, rd, er);
      chk("stale_result", rd, 32'he000);
      for (int r = 0; r < 4; r++) begin
         for (int f = 0; f < 3; f++) begin
            apb(1'b1, arc_pkg::CTRL_OFS, 32'(f), rd, er);
            repeat (3) @(posedge pclk);
            chk_fn(2'(f), r);
         end
         n = upd_n;
         conv(16'h7999);
         chk("upd_echo", 32'(upd_n), 32'(n + 1));
         chk("step_up", 32'(relay), 32'h1 << (r < 3 ? r + 1 : 3));
      end
      chk("blink_on", 32'(display_blank), 32'h1);
      conv(16'h3999);
      chk("blink_off", 32'(display_blank), 32'h0);
      apb(1'b0, arc_pkg::STAT_OFS, 32'h0, rd, er);
      chk("stat_over", rd, 32'h0f);
   endtask : t_sweep

   // Hold, in-range result, then underrange walk down to the bottom
   task automatic t_hold;
      apb(1'b1, arc_pkg::CTRL_OFS, 32'h4, rd, er);
      conv(16'hf000);
      chk("hold", 32'(relay), 32'h8);
      apb(1'b1, arc_pkg::CTRL_OFS, 32'h0, rd, er);
      conv(16'h4123);
      chk("in_range", 32'(relay), 32'h8);
      chk("seg_on", 32'(top_seg_bc), 32'h1);
      apb(1'b0, arc_pkg::STAT_OFS, 32'h0, rd, er);
      chk("stat_pos", rd, 32'h47);
      apb(1'b0, arc_pkg::RES_OFS, 32'h0, rd, er);
      chk("result", rd, 32'h4123);
      for (int k = 0; k < 4; k++) begin
         conv(16'hb000);
         chk("step_dn", 32'(relay), 32'h8 >> (k < 3 ? k + 1 : 3));
      end
      chk("seg_off", 32'(top_seg_bc), 32'h0);
      apb(1'b0, arc_pkg::STAT_OFS, 32'h0, rd, er);
      chk("stat_under", rd, 32'h90);
      // Twelve conversions ran in the sweep and the hold scenario
      apb(1'b0, arc_pkg::CONV_OFS, 32'h0, rd, er);
      chk("conv_count", rd, 32'h0c);
   endtask : t_hold

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      t_reset();
      t_sweep();
      t_hold();
      end_of_test();
   end

endmodule : testbench
`default_nettype wire
